// >>> core/rsu_pkg.sv
// Purpose: shared constants and types of the remote upgrade status logic
// Assumes: 32-bit AXI4-Lite register window, byte addresses
// Notes: master state codes appear in status bits 31:30
package rsu_pkg;
  // register byte offsets
  localparam logic [7:0] RSU_OFS_STATUS = 8'h00;
  localparam logic [7:0] RSU_OFS_CTRL = 8'h04;
  localparam logic [7:0] RSU_OFS_APP_LOC = 8'h08;
  localparam logic [7:0] RSU_OFS_WDOG = 8'h0C;
  localparam logic [7:0] RSU_OFS_WDOG_KICK = 8'h10;
  localparam logic [7:0] RSU_OFS_PREV1 = 8'h14;
  localparam logic [7:0] RSU_OFS_PREV2 = 8'h18;
  // control register fields
  localparam int RSU_CTRL_RECONF_BIT = 0;
  localparam int RSU_CTRL_VIEW_BIT = 1;
  // watchdog register fields
  localparam int RSU_WDOG_EN_BIT = 29;
  localparam int RSU_WDOG_TO_W = 29;
  // status word layout
  localparam int RSU_ST_MS_LSB = 30;
  localparam int RSU_LOC_W = 24;
  // factory start locations after power-up
  localparam logic [23:0] RSU_SERIAL_FACTORY_LOC = 24'h000000;
  localparam logic [23:0] RSU_PARALLEL_FACTORY_LOC = 24'h010000;
  // reset values
  localparam logic [23:0] RSU_APP_LOC_RST = 24'h000000;
  localparam logic [28:0] RSU_WDOG_TO_RST = 29'h1FFFFFFF;
  localparam logic [31:0] RSU_PREV_RST = 32'h00000000;
  // master state codes reported to software
  localparam logic [1:0] RSU_MS_FACTORY = 2'h0;
  localparam logic [1:0] RSU_MS_APP = 2'h1;
  // cycles to let the strap pass its synchroniser
  localparam logic [1:0] RSU_STRAP_WAIT = 2'h3;
  // AXI responses
  localparam logic [1:0] RSU_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSU_RESP_SLVERR = 2'h2;

  // request to the configuration engine
  typedef struct packed {
    logic start;
    logic [23:0] location;
  } rsu_cfg_req_t;

  // watchdog settings held for the application
  typedef struct packed {
    logic enable;
    logic [28:0] timeout;
  } rsu_wdog_cfg_t;

  // reasons recorded when an application configuration ends
  typedef struct packed {
    logic wdog;
    logic ext_reset;
    logic error;
    logic request;
  } rsu_cause_t;
endpackage

// >>> core/rsu_sync.sv
// Purpose: two-flop synchroniser for pins entering the ref_clk domain
// Assumes: slow level inputs, no pulses shorter than two cycles
// Notes: the first flop is read only by the second
`timescale 1ns/1ps
module rsu_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // metastability guard
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= pin_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> core/rsu_wdog.sv
// Purpose: user watchdog counter of the application configuration
// Assumes: arm is a level held while the application is in user mode
// Notes: count reloads on arming and on each restart
`timescale 1ns/1ps
module rsu_wdog
  import rsu_pkg::*;
#(
  parameter int TO_W = RSU_WDOG_TO_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic arm,
  input wire logic restart,
  input wire logic [TO_W-1:0] timeout,
  output logic expired
);
  logic [TO_W-1:0] count;
  logic armed_q;

  // remember arming to find its first cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= arm;
    end
  end

  // reload on arm or restart, then count down to zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (!arm) begin
      count <= '0;
    end else if (!armed_q || restart) begin
      count <= timeout;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // one pulse when the armed count runs out
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      expired <= 1'b0;
    end else begin
      expired <= arm && armed_q && !restart && (count == 'd1);
    end
  end
endmodule

// >>> core/rsu_core.sv
// Purpose: remote upgrade master state machine, watchdog and status
// Assumes: configuration engine runs on ref_clk; pins are asynchronous
// Notes: registers are reached over AXI4-Lite with 32-bit data
// Function
// - serial scheme factory image starts at zero
// - parallel scheme factory image starts at 010000
// - boundary-scan instruction replaces parallel factory location
// - any error falls back to factory image
// - application image may start at any sector
// - fabric request starts a new configuration cycle
// - fabric sets watchdog enable and time-out
// - external config reset starts reconfiguration
// - watchdog expiry starts reconfiguration
// - status bits 31:30 give master state
// - factory view: zero padding, then start location
// - application view 1: bit 29 watchdog armed
// - application view 1: 29-bit time-out value
// - application view 2: zero padding, start location
// - two previous application records kept for debug
// - watchdog off in factory and application loading
// - watchdog armed once application reaches user mode
// - power-up loads factory image first
`timescale 1ns/1ps
module rsu_core
  import rsu_pkg::*;
#(
  parameter int SECTOR_BITS = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_config_reset_n,
  input wire logic parallel_flash_scheme,
  input wire logic factory_start_location_instruction,
  input wire logic [23:0] factory_location_value,
  output rsu_cfg_req_t cfg_req,
  input wire logic cfg_user_mode,
  input wire logic cfg_error,
  output logic wdog_armed
);
  typedef enum logic [2:0] {
    ST_POWER_UP, ST_EXT_RESET, ST_FACTORY_LOAD, ST_FACTORY_USER,
    ST_APP_LOAD, ST_APP_USER
  } rsu_state_t;

  rsu_state_t state;
  rsu_state_t next_state;
  logic ext_rst_n;
  logic scheme_par;
  logic [1:0] strap_cnt;
  logic fact_override;
  logic [23:0] fact_loc;
  logic [23:0] app_loc;
  logic [23:0] cur_loc;
  rsu_wdog_cfg_t wdog_cfg;
  logic view_sel;
  logic reconf_req;
  logic wdog_kick;
  logic wdog_expired;
  logic [31:0] prev1;
  logic [31:0] prev2;
  logic [31:0] status_word;
  logic [1:0] ms_code;
  logic app_ok;
  logic leave_app;
  rsu_cause_t cause;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_go;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;

  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // pins from outside the clock domain
  rsu_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_rst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(external_config_reset_n),
    .sync_out(ext_rst_n)
  );

  rsu_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_scheme (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(parallel_flash_scheme),
    .sync_out(scheme_par)
  );

  // ---------------- AXI4-Lite write channel ----------------
  // address and data are taken in either order and held until both exist
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // writable and write-effect offsets decode as a hit
  always_comb begin
    unique case (aw_addr)
      RSU_OFS_CTRL, RSU_OFS_APP_LOC, RSU_OFS_WDOG,
      RSU_OFS_WDOG_KICK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // response one cycle after both halves are present
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RSU_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RSU_RESP_OKAY : RSU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- register writes ----------------
  // the watchdog settings stay stored; arming decides whether they act
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdog_cfg <= '{enable: 1'b0, timeout: RSU_WDOG_TO_RST};
    end else if (wr_go && aw_addr == RSU_OFS_WDOG) begin
      {wdog_cfg.enable, wdog_cfg.timeout} <= 30'(
        merge({2'b00, wdog_cfg.enable, wdog_cfg.timeout},
              w_data, w_strb));
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      app_loc <= RSU_APP_LOC_RST;
    end else if (wr_go && aw_addr == RSU_OFS_APP_LOC) begin
      app_loc <= 24'(merge({8'h00, app_loc}, w_data, w_strb));
    end
  end

  // view select is a level; reconfiguration request is a write pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      view_sel <= 1'b0;
      reconf_req <= 1'b0;
      wdog_kick <= 1'b0;
    end else begin
      reconf_req <= wr_go && aw_addr == RSU_OFS_CTRL && w_strb[0] &&
                    w_data[RSU_CTRL_RECONF_BIT];
      wdog_kick <= wr_go && aw_addr == RSU_OFS_WDOG_KICK;
      if (wr_go && aw_addr == RSU_OFS_CTRL && w_strb[0]) begin
        view_sel <= w_data[RSU_CTRL_VIEW_BIT];
      end
    end
  end

  // ---------------- factory start location ----------------
  // the strap is read only after it has passed its synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != RSU_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // boundary-scan override survives reconfiguration, not a full reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fact_override <= 1'b0;
      fact_loc <= RSU_SERIAL_FACTORY_LOC;
    end else if (factory_start_location_instruction && scheme_par &&
                 strap_cnt == RSU_STRAP_WAIT) begin
      fact_override <= 1'b1;
      fact_loc <= factory_location_value;
    end else if (state == ST_POWER_UP && !fact_override) begin
      // tracked through power-up so the first start sees the settled strap
      fact_loc <= scheme_par ? RSU_PARALLEL_FACTORY_LOC
                             : RSU_SERIAL_FACTORY_LOC;
    end
  end

  // ---------------- master state machine ----------------
  // an application image may begin only on a sector boundary
  assign app_ok = app_loc[SECTOR_BITS-1:0] == '0;

  always_comb begin
    next_state = state;
    if (!ext_rst_n) begin
      next_state = ST_EXT_RESET;
    end else begin
      unique case (state)
        ST_POWER_UP: begin
          if (strap_cnt == RSU_STRAP_WAIT) begin
            next_state = ST_FACTORY_LOAD;
          end
        end
        ST_EXT_RESET: next_state = ST_FACTORY_LOAD;
        ST_FACTORY_LOAD: begin
          if (cfg_user_mode) begin
            next_state = ST_FACTORY_USER;
          end
        end
        ST_FACTORY_USER: begin
          if (reconf_req) begin
            next_state = app_ok ? ST_APP_LOAD : ST_FACTORY_LOAD;
          end
        end
        ST_APP_LOAD: begin
          if (cfg_error) begin
            next_state = ST_FACTORY_LOAD;
          end else if (cfg_user_mode) begin
            next_state = ST_APP_USER;
          end
        end
        ST_APP_USER: begin
          if (wdog_expired || cfg_error || reconf_req) begin
            next_state = ST_FACTORY_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_POWER_UP;
    end else begin
      state <= next_state;
    end
  end

  // start pulse and location toward the configuration engine
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_req <= '{start: 1'b0, location: RSU_SERIAL_FACTORY_LOC};
      cur_loc <= RSU_SERIAL_FACTORY_LOC;
    end else begin
      cfg_req.start <= 1'b0;
      if (next_state == ST_FACTORY_LOAD && state != ST_FACTORY_LOAD) begin
        cfg_req.start <= 1'b1;
        cfg_req.location <= fact_loc;
        cur_loc <= fact_loc;
      end else if (next_state == ST_APP_LOAD && state != ST_APP_LOAD) begin
        cfg_req.start <= 1'b1;
        cfg_req.location <= app_loc;
        cur_loc <= app_loc;
      end else if (state == ST_FACTORY_LOAD && cfg_error) begin
        cfg_req.start <= 1'b1;
      end
    end
  end

  // ---------------- user watchdog ----------------
  // never armed while loading or in factory configuration
  assign wdog_armed = state == ST_APP_USER && wdog_cfg.enable;

  rsu_wdog #(.TO_W(RSU_WDOG_TO_W)) u_wdog (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .arm(wdog_armed),
    .restart(wdog_kick),
    .timeout(wdog_cfg.timeout),
    .expired(wdog_expired)
  );

  // ---------------- status and history ----------------
  assign ms_code = (state == ST_APP_LOAD || state == ST_APP_USER) ?
                   RSU_MS_APP : RSU_MS_FACTORY;

  // layout depends on the master state and on the chosen view
  always_comb begin
    if (ms_code == RSU_MS_FACTORY) begin
      status_word = {ms_code, 6'h00, cur_loc};
    end else if (!view_sel) begin
      status_word = {ms_code, wdog_armed, wdog_cfg.timeout};
    end else begin
      status_word = {ms_code, 6'h00, cur_loc};
    end
  end

  // a record is pushed whenever an application configuration ends
  assign leave_app = (state == ST_APP_LOAD || state == ST_APP_USER) &&
                     next_state != ST_APP_USER && next_state != ST_APP_LOAD;
  assign cause = '{wdog: wdog_expired && state == ST_APP_USER,
                   ext_reset: !ext_rst_n, error: cfg_error,
                   request: reconf_req};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev1 <= RSU_PREV_RST;
      prev2 <= RSU_PREV_RST;
    end else if (leave_app) begin
      prev2 <= prev1;
      prev1 <= {RSU_MS_APP, cause, 2'b00, cur_loc};
    end
  end

  // ---------------- AXI4-Lite read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      RSU_OFS_STATUS: rd_val = status_word;
      RSU_OFS_CTRL: rd_val = {30'h0, view_sel, 1'b0};
      RSU_OFS_APP_LOC: rd_val = {8'h00, app_loc};
      RSU_OFS_WDOG: rd_val = {2'b00, wdog_cfg.enable, wdog_cfg.timeout};
      RSU_OFS_WDOG_KICK: rd_val = 32'h00000000;
      RSU_OFS_PREV1: rd_val = prev1;
      RSU_OFS_PREV2: rd_val = prev2;
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // data captured when the address is taken, held until rready
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RSU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RSU_RESP_OKAY : RSU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> bench/rsu_core_properties.sv
// Purpose: port-level checks of the remote upgrade status block
// Assumes: one ref_clk domain, resetn asynchronous and active low
// Notes: attached to every rsu_core by the bind at the foot
`timescale 1ns/1ps
module rsu_core_properties
  import rsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_config_reset_n,
  input wire logic parallel_flash_scheme,
  input wire logic factory_start_location_instruction,
  input wire logic [23:0] factory_location_value,
  input wire rsu_cfg_req_t cfg_req,
  input wire logic cfg_user_mode,
  input wire logic cfg_error,
  input wire logic wdog_armed
);
  // everything here lives in the one clock domain
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // a start request lasts exactly one cycle
  chk_start_one_cycle: assert property (cfg_req.start |=> !cfg_req.start)
    else $error("start request longer than one cycle");
  // the watchdog stays off while an image loads
  chk_load_unarmed: assert property (
    cfg_req.start |-> !wdog_armed ##1 !wdog_armed)
    else $error("watchdog armed during image load");
  // arming comes from user mode entry or a settings write only
  chk_arm_cause: assert property ($rose(wdog_armed) |->
    $past(cfg_user_mode) || $rose(s_axi_bvalid))
    else $error("watchdog armed without user mode");
  // releasing the external reset leads to a new load
  chk_ext_reconf: assert property (
    $rose(external_config_reset_n) |-> ##[1:10] cfg_req.start)
    else $error("no reload after external reset");
  // status word: state code, then zero pad in factory state
  chk_status_layout: assert property (
    s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == RSU_OFS_STATUS |=> s_axi_rdata[31:30] == RSU_MS_APP ||
    (s_axi_rdata[31:30] == RSU_MS_FACTORY && s_axi_rdata[29:24] == 6'h00))
    else $error("status word layout wrong");
  // an unmapped read returns zero with an error response
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h1C |=> s_axi_rresp == RSU_RESP_SLVERR &&
    s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  // a taken read address is answered on the next cycle
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // no new read address is taken while data waits
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  // an answered read with rready high clears at once
  chk_read_clear: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
  // write response follows a joint address and data take
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  // no write half is taken while a response is pending
  chk_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule

bind rsu_core rsu_core_properties i_chk (
  .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .external_config_reset_n, .parallel_flash_scheme,
  .factory_start_location_instruction, .factory_location_value, .cfg_req,
  .cfg_user_mode, .cfg_error, .wdog_armed
);

// >>> bench/rsu_cfg_model.sv
// Purpose: behavioural configuration engine facing the upgrade block
// Assumes: one load per start request, fixed load latency
// Notes: fail_next is latched at the start, so the bench may drop it early
`timescale 1ns/1ps
module rsu_cfg_model
  import rsu_pkg::*;
#(
  parameter int LAT = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire rsu_cfg_req_t cfg_req,
  input wire logic fail_next,
  output logic cfg_user_mode,
  output logic cfg_error
);
  logic [3:0] cnt;
  logic err_q;

  // count down the load, then report user mode or a load error
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      err_q <= 1'b0;
      cfg_user_mode <= 1'b0;
      cfg_error <= 1'b0;
    end else begin
      cfg_user_mode <= 1'b0;
      cfg_error <= 1'b0;
      if (cfg_req.start) begin
        cnt <= 4'(LAT);
        err_q <= fail_next;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          cfg_user_mode <= !err_q;
          cfg_error <= err_q; // pulse, as the real engine reports
        end
      end
    end
  end
endmodule

// >>> bench/tb_rsu_core.sv
// Purpose: self-checking bench of the remote upgrade status block
// Assumes: AXI4-Lite master here, config engine model on the far side
// Notes: bready and rready stay high, so responses never stall
`timescale 1ns/1ps
module tb_rsu_core;
  import rsu_pkg::*;
  logic ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdog_armed, fail_next;
  logic external_config_reset_n, parallel_flash_scheme, cfg_user_mode;
  logic factory_start_location_instruction, cfg_error;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] factory_location_value;
  rsu_cfg_req_t cfg_req;
  int fail_count, cmp_count, cycles;

  rsu_core i_dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_config_reset_n, .parallel_flash_scheme,
    .factory_start_location_instruction, .factory_location_value, .cfg_req,
    .cfg_user_mode, .cfg_error, .wdog_armed);
  rsu_cfg_model i_eng (.ref_clk, .resetn, .cfg_req, .fail_next,
    .cfg_user_mode, .cfg_error);

  always #5 ref_clk = ~ref_clk;

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hung wait ends the run as a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // each half is dropped at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // always moves at least one edge, so one pulse is never seen twice
  task automatic wait_start(input logic [23:0] loc);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cfg_req.start !== 1'b1 && n < 60);
    check({7'h0, cfg_req.start, cfg_req.location}, {8'h01, loc});
  endtask

  task automatic do_reset(input logic sch, input logic [23:0] loc);
    resetn <= 1'b0;
    parallel_flash_scheme <= sch;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_start(loc);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_ext_reset(input logic [23:0] loc);
    external_config_reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    external_config_reset_n <= 1'b1;
    wait_start(loc);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_bus_refuse();
    axi_rd(8'h1C, 32'h00000000, RSU_RESP_SLVERR);
    axi_wr(RSU_OFS_STATUS, 32'hFFFFFFFF, RSU_RESP_SLVERR);
    axi_wr(RSU_OFS_PREV1, 32'hFFFFFFFF, RSU_RESP_SLVERR);
    axi_rd(RSU_OFS_STATUS, 32'h00000000, RSU_RESP_OKAY);
  endtask

  // kicks are spaced well inside the ten-cycle time-out
  task automatic t_app_watchdog();
    axi_wr(RSU_OFS_APP_LOC, 32'h00120000, RSU_RESP_OKAY);
    axi_wr(RSU_OFS_WDOG, 32'h2000000A, RSU_RESP_OKAY);
    check({31'h0, wdog_armed}, 32'h0);
    axi_wr(RSU_OFS_CTRL, 32'h00000001, RSU_RESP_OKAY);
    wait_start(24'h120000);
    repeat (7) @(posedge ref_clk);
    check({31'h0, wdog_armed}, 32'h1);
    axi_wr(RSU_OFS_WDOG_KICK, 32'h0, RSU_RESP_OKAY);
    axi_rd(RSU_OFS_STATUS, 32'h6000000A, RSU_RESP_OKAY);
    axi_wr(RSU_OFS_WDOG_KICK, 32'h0, RSU_RESP_OKAY);
    axi_wr(RSU_OFS_CTRL, 32'h00000002, RSU_RESP_OKAY);
    axi_rd(RSU_OFS_STATUS, 32'h40120000, RSU_RESP_OKAY);
    repeat (4) begin
      axi_wr(RSU_OFS_WDOG_KICK, 32'h0, RSU_RESP_OKAY);
      check({31'h0, wdog_armed}, 32'h1);
    end
    wait_start(RSU_SERIAL_FACTORY_LOC);
    repeat (8) @(posedge ref_clk);
    axi_rd(RSU_OFS_PREV1, 32'h60120000, RSU_RESP_OKAY);
  endtask

  task automatic t_error_fallback();
    fail_next <= 1'b1;
    axi_wr(RSU_OFS_CTRL, 32'h00000001, RSU_RESP_OKAY);
    wait_start(24'h120000);
    fail_next <= 1'b0;
    wait_start(RSU_SERIAL_FACTORY_LOC);
    repeat (8) @(posedge ref_clk);
    axi_rd(RSU_OFS_PREV1, 32'h48120000, RSU_RESP_OKAY);
    axi_rd(RSU_OFS_PREV2, 32'h60120000, RSU_RESP_OKAY);
    axi_wr(RSU_OFS_APP_LOC, 32'h00120001, RSU_RESP_OKAY);
    axi_wr(RSU_OFS_CTRL, 32'h00000001, RSU_RESP_OKAY);
    wait_start(RSU_SERIAL_FACTORY_LOC);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_parallel();
    do_reset(1'b1, RSU_PARALLEL_FACTORY_LOC);
    axi_rd(RSU_OFS_STATUS, 32'h00010000, RSU_RESP_OKAY);
    factory_location_value <= 24'h050000;
    factory_start_location_instruction <= 1'b1;
    @(posedge ref_clk);
    factory_start_location_instruction <= 1'b0;
    t_ext_reset(24'h050000);
    axi_rd(RSU_OFS_STATUS, 32'h00050000, RSU_RESP_OKAY);
  endtask

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    external_config_reset_n = 1'b1;
    parallel_flash_scheme = 1'b0;
    factory_start_location_instruction = 1'b0;
    factory_location_value = 24'h000000;
    fail_next = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    @(posedge ref_clk);
    do_reset(1'b0, RSU_SERIAL_FACTORY_LOC);
    t_bus_refuse();
    t_app_watchdog();
    t_error_fallback();
    t_ext_reset(RSU_SERIAL_FACTORY_LOC);
    t_parallel();
    close_out();
  end
endmodule
